// [asr_dev.sv]
// Converter end: command interpreter, register block, result readout.
// Assumes the controller leaves at least 16 core clocks between bytes.
`timescale 1ns/1ns
`default_nettype none
module asr_dev #(
    parameter int TMO_CLKS = asr_pkg::SER_TMO_CLKS
) (
    input wire logic core_clk_i,
    input wire logic rst_i,
    asr_link_if.dev lnk,
    input wire logic [23:0] result_i,
    input wire logic result_valid_i,
    output logic conv_run_o,
    output logic [2:0] rate_sel_o
);
    localparam int TW = $clog2(TMO_CLKS + 1);
    typedef enum logic [2:0] {S_CMD, S_WCNT, S_WDAT, S_RCNT, S_RDAT, S_RES}
        asr_dev_st_t;

    // ==========================================================
    // Link clock domain
    logic [2:0] bcnt;
    logic [6:0] rsh;
    logic [6:0] tsh;
    logic [7:0] rx_byte;
    logic tog;
    logic abort;
    logic [7:0] tx;
    wire frame_clr = lnk.cs_n | abort;

    // Deselect or timeout realigns the bit counter while the clock is idle
    always_ff @(posedge lnk.sclk or posedge frame_clr)
    begin
        if (frame_clr)
        begin
            bcnt <= 3'h0;
            rsh <= 7'h00;
            tsh <= 7'h00;
            rx_byte <= 8'h00;
            tog <= 1'b0;
        end
        else
        begin
            bcnt <= bcnt + 3'h1;
            rsh <= {rsh[5:0], lnk.din};
            tsh <= (bcnt == 3'h0) ? tx[6:0] : {tsh[5:0], 1'b0};
            if (bcnt == 3'h7)
            begin
                rx_byte <= {rsh, lnk.din};
                tog <= ~tog;
            end
        end
    end
    // First bit comes straight from the prepared byte
    assign lnk.dout = (bcnt == 3'h0) ? tx[7] : tsh[6];

    // ==========================================================
    // Core domain synchronisers and timeout
    logic [1:0] sclk_sy;
    logic [1:0] cs_sy;
    logic [1:0] start_sy;
    logic [1:0] tog_sy;
    logic tog_last;
    logic [1:0] abort_sh;
    logic [TW-1:0] tmo_cnt;
    logic [7:0] cfg [0:asr_pkg::NREG-1];

    always_ff @(posedge core_clk_i)
    begin
        if (rst_i)
        begin
            sclk_sy <= 2'h0;
            cs_sy <= 2'h3;
            start_sy <= 2'h0;
            tog_sy <= 2'h0;
            tog_last <= 1'b0;
            abort_sh <= 2'h0;
        end
        else
        begin
            sclk_sy <= {sclk_sy[0], lnk.sclk};
            cs_sy <= {cs_sy[0], lnk.cs_n};
            start_sy <= {start_sy[0], lnk.start};
            tog_sy <= {tog_sy[0], tog};
            tog_last <= tog_sy[1];
            abort_sh <= {abort_sh[0], abort};
        end
    end

    wire tmo_en = cfg[asr_pkg::REG_SETUP0][asr_pkg::B_TMO_EN];
    wire tmo_hit = (tmo_cnt == TW'(TMO_CLKS - 1));
    wire tmo_full = (tmo_cnt == TW'(TMO_CLKS));
    // One-cycle abort, then the count parks: an idle link must not
    // stay in reset or the next first rise and any result are lost
    always_ff @(posedge core_clk_i)
    begin
        if (rst_i || sclk_sy[1] || !tmo_en)
        begin
            tmo_cnt <= '0;
            abort <= 1'b0;
        end
        else
        begin
            abort <= tmo_hit;
            if (!tmo_full)
                tmo_cnt <= tmo_cnt + TW'(1);
        end
    end

    // ==========================================================
    // Command interpreter
    asr_dev_st_t st;
    logic [3:0] addr;
    logic [7:0] cnt;
    logic [1:0] idx;
    logic [23:0] res;
    logic ready_n;
    logic cont;
    logic run_cmd;

    // Abort clears the byte toggle; mask the false edge it leaves behind
    wire rx_evt = (tog_sy[1] != tog_last) & ~cs_sy[1] & ~abort &
        (abort_sh == 2'h0);
    wire chk_en = cfg[asr_pkg::REG_SETUP1][asr_pkg::B_CHK_EN];
    wire [1:0] res_last = chk_en ? 2'h3 : 2'h2;
    wire mid_read = (st == S_RES) & ((idx != 2'h0) | ~cont);
    wire take = result_valid_i & conv_run_o & ~mid_read;
    wire [3:0] wr_hi = rx_byte[7:4];

    // Status bit in setup register two follows the ready line
    function automatic logic [7:0] rd_reg(input logic [3:0] a);
        rd_reg = 8'h00;
        if (a == asr_pkg::REG_SETUP2)
            rd_reg = {ready_n, cfg[a][6:0]};
        else if (a < 4'(asr_pkg::NREG))
            rd_reg = cfg[a];
    endfunction

    function automatic logic [7:0] res_byte(input logic [23:0] w,
        input logic [1:0] i);
        case (i)
            2'h0: res_byte = w[23:16];
            2'h1: res_byte = w[15:8];
            2'h2: res_byte = w[7:0];
            default: res_byte = w[23:16] + w[15:8] + w[7:0];
        endcase
    endfunction

    always_ff @(posedge core_clk_i)
    begin
        if (rst_i)
        begin
            st <= S_CMD;
            addr <= 4'h0;
            cnt <= 8'h00;
            idx <= 2'h0;
            tx <= 8'h00;
            res <= 24'h000000;
            ready_n <= 1'b1;
            cont <= 1'b1;
            run_cmd <= 1'b0;
            for (int i = 0; i < asr_pkg::NREG; i++)
                cfg[i] <= asr_pkg::reg_reset(4'(i));
        end
        else if (rx_evt)
        begin
            case (st)
                S_CMD:
                begin
                    if (cont)
                    begin
                        if (rx_byte == asr_pkg::OP_STOP_CONT)
                            cont <= 1'b0;
                    end
                    else if (rx_byte == asr_pkg::OP_CONT)
                        cont <= 1'b1;
                    else if (rx_byte == asr_pkg::OP_START)
                        run_cmd <= 1'b1;
                    else if (rx_byte == asr_pkg::OP_RDATA)
                    begin
                        if (!ready_n)
                        begin
                            st <= S_RES;
                            idx <= 2'h0;
                            tx <= res_byte(res, 2'h0);
                        end
                    end
                    else if (wr_hi == asr_pkg::OP_WREG_HI)
                    begin
                        st <= S_WCNT;
                        addr <= rx_byte[3:0];
                    end
                    else if (wr_hi == asr_pkg::OP_RREG_HI)
                    begin
                        st <= S_RCNT;
                        addr <= rx_byte[3:0];
                    end
                end
                S_WCNT:
                begin
                    cnt <= rx_byte;
                    st <= S_WDAT;
                end
                S_WDAT:
                begin
                    // Ready bit of setup register two is read-only
                    if (addr == asr_pkg::REG_SETUP2)
                        cfg[addr] <= {1'b0, rx_byte[6:0]};
                    else if (addr < 4'(asr_pkg::NREG))
                        cfg[addr] <= rx_byte;
                    addr <= addr + 4'h1;
                    cnt <= cnt - 8'h01;
                    if (cnt == 8'h00)
                        st <= S_CMD;
                end
                S_RCNT:
                begin
                    cnt <= rx_byte;
                    tx <= rd_reg(addr);
                    st <= S_RDAT;
                end
                S_RDAT:
                begin
                    addr <= addr + 4'h1;
                    cnt <= cnt - 8'h01;
                    tx <= rd_reg(addr + 4'h1);
                    if (cnt == 8'h00)
                    begin
                        st <= S_CMD;
                        tx <= 8'h00;
                    end
                end
                S_RES:
                begin
                    idx <= idx + 2'h1;
                    tx <= res_byte(res, idx + 2'h1);
                    if (idx == res_last)
                    begin
                        st <= S_CMD;
                        idx <= 2'h0;
                        tx <= 8'h00;
                        ready_n <= 1'b1;
                    end
                end
                default: st <= S_CMD;
            endcase
        end
        else if (cs_sy[1] || abort)
        begin
            // A waiting result survives a deselect or timeout
            if (st != S_RES || idx != 2'h0)
            begin
                st <= S_CMD;
                idx <= 2'h0;
                tx <= 8'h00;
            end
        end
        else if (take)
        begin
            res <= result_i;
            ready_n <= 1'b0;
            if (cont)
            begin
                st <= S_RES;
                idx <= 2'h0;
                tx <= res_byte(result_i, 2'h0);
            end
        end
    end

    // ==========================================================
    // Outputs
    always_ff @(posedge core_clk_i)
    begin
        if (rst_i)
        begin
            conv_run_o <= 1'b0;
            rate_sel_o <= 3'h0;
            lnk.dout_oe <= 1'b0;
            lnk.result_ready_n <= 1'b1;
        end
        else
        begin
            conv_run_o <= start_sy[1] | run_cmd;
            rate_sel_o <= cfg[asr_pkg::REG_SETUP2][2:0];
            lnk.dout_oe <= ~cs_sy[1];
            lnk.result_ready_n <= ready_n;
        end
    end
endmodule
`default_nettype wire

// [asr_host.sv]
// Controller end: power-up wait, configuration, readback, result fetch.
// Assumes a single converter on the link and a pull-down on data-out.
`timescale 1ns/1ns
`default_nettype none
module asr_host #(
    parameter int PWRUP_CLKS = asr_pkg::PWRUP_CLKS,
    parameter int HALF = 4,
    parameter int GAP = 16,
    parameter bit START_BY_CMD = 1'b0,
    parameter bit CONT_MODE = 1'b1,
    parameter bit USE_AMP_TRIG = 1'b0
) (
    input wire logic core_clk_i,
    input wire logic rst_i,
    asr_link_if.host lnk,
    input wire logic amp_trigger_i,
    output logic [23:0] res_data_o,
    output logic res_valid_o,
    input wire logic res_ready_i,
    output logic init_done_o,
    output logic verify_err_o,
    output logic chk_err_o
);
    localparam int PWW = $clog2(PWRUP_CLKS + 1);
    localparam bit CHK = asr_pkg::SETUP1_VAL[asr_pkg::B_CHK_EN];
    localparam logic [1:0] NLAST = CHK ? 2'h3 : 2'h2;
    typedef enum logic [2:0] {H_PWR, H_SEQ, H_RUN, H_RCMD, H_RDAT, H_WHI}
        asr_host_st_t;

    // ==========================================================
    // Pin synchronisers
    logic [1:0] miso_sy;
    logic [1:0] rdy_sy;
    logic [1:0] trig_sy;

    always_ff @(posedge core_clk_i)
    begin
        if (rst_i)
        begin
            miso_sy <= 2'h0;
            rdy_sy <= 2'h3;
            trig_sy <= 2'h0;
        end
        else
        begin
            miso_sy <= {miso_sy[0], lnk.miso};
            rdy_sy <= {rdy_sy[0], lnk.result_ready_n};
            trig_sy <= {trig_sy[0], amp_trigger_i};
        end
    end

    // ==========================================================
    // Byte engine: clock idles low, data sampled before each rise
    logic eng_busy;
    logic eng_done;
    logic eng_gap;
    logic [7:0] ph;
    logic [2:0] bit_n;
    logic [7:0] tsh;
    logic [7:0] eng_rx;
    logic eng_go;
    logic [7:0] eng_tx;
    wire [7:0] ph_lim = eng_gap ? 8'(GAP - 1) : 8'(HALF - 1);

    always_ff @(posedge core_clk_i)
    begin
        if (rst_i)
        begin
            eng_busy <= 1'b0;
            eng_done <= 1'b0;
            eng_gap <= 1'b0;
            ph <= 8'h00;
            bit_n <= 3'h0;
            tsh <= 8'h00;
            eng_rx <= 8'h00;
            lnk.sclk <= 1'b0;
        end
        else
        begin
            eng_done <= 1'b0;
            if (!eng_busy)
            begin
                if (eng_go)
                begin
                    eng_busy <= 1'b1;
                    eng_gap <= 1'b0;
                    ph <= 8'h00;
                    bit_n <= 3'h0;
                    tsh <= eng_tx;
                end
            end
            else if (ph != ph_lim)
                ph <= ph + 8'h01;
            else
            begin
                ph <= 8'h00;
                if (eng_gap)
                begin
                    eng_busy <= 1'b0;
                    eng_done <= 1'b1;
                end
                else if (!lnk.sclk)
                begin
                    lnk.sclk <= 1'b1;
                    eng_rx <= {eng_rx[6:0], miso_sy[1]};
                end
                else
                begin
                    lnk.sclk <= 1'b0;
                    tsh <= {tsh[6:0], 1'b0};
                    bit_n <= bit_n + 3'h1;
                    eng_gap <= (bit_n == 3'h7);
                end
            end
        end
    end
    assign lnk.din = tsh[7];

    // ==========================================================
    // Sequencer
    asr_host_st_t st;
    logic [PWW-1:0] pw_cnt;
    logic [4:0] sq;
    logic [1:0] nb;
    logic [23:0] acc;
    logic push;
    logic [23:0] push_data;
    logic [1:0] fcnt;

    function automatic logic [7:0] seq_byte(input logic [4:0] i);
        if (i == 5'h00)
            seq_byte = asr_pkg::OP_STOP_CONT;
        else if (i == 5'h01)
            seq_byte = {asr_pkg::OP_WREG_HI, 4'h0};
        else if (i == 5'h02 || i == asr_pkg::SEQ_RDATA - 5'h01)
            seq_byte = asr_pkg::BLOCK_M1;
        else if (i < asr_pkg::SEQ_RCMD)
            seq_byte = asr_pkg::init_val(4'(i - asr_pkg::SEQ_WDATA));
        else if (i == asr_pkg::SEQ_RCMD)
            seq_byte = {asr_pkg::OP_RREG_HI, 4'h0};
        else if (i == asr_pkg::SEQ_START && START_BY_CMD)
            seq_byte = asr_pkg::OP_START;
        else if (i == asr_pkg::SEQ_CONT && CONT_MODE)
            seq_byte = asr_pkg::OP_CONT;
        else
            seq_byte = asr_pkg::OP_NOP;
    endfunction

    wire [3:0] rb_idx = 4'(sq - asr_pkg::SEQ_RDATA);
    // Ready bit is live status, so it is left out of the compare
    wire [7:0] rb_mask = (rb_idx == asr_pkg::REG_SETUP2) ? 8'h7f : 8'hff;
    wire rb_bad = ((eng_rx ^ asr_pkg::init_val(rb_idx)) & rb_mask) != 8'h00;
    wire in_rb = (sq >= asr_pkg::SEQ_RDATA) && (sq <= asr_pkg::SEQ_RLAST);
    wire buf_full = (fcnt == 2'h2);
    wire rdy_low = ~rdy_sy[1];
    wire need = (st == H_SEQ) | (st == H_RCMD) | (st == H_RDAT);
    assign eng_go = need & ~eng_busy & ~eng_done;
    assign eng_tx = (st == H_SEQ) ? seq_byte(sq) :
        (st == H_RCMD) ? asr_pkg::OP_RDATA : asr_pkg::OP_NOP;
    wire [7:0] sum3 = acc[23:16] + acc[15:8] + acc[7:0];

    always_ff @(posedge core_clk_i)
    begin
        if (rst_i)
        begin
            st <= H_PWR;
            pw_cnt <= '0;
            sq <= 5'h00;
            nb <= 2'h0;
            acc <= 24'h000000;
            push <= 1'b0;
            push_data <= 24'h000000;
            init_done_o <= 1'b0;
            verify_err_o <= 1'b0;
            chk_err_o <= 1'b0;
        end
        else
        begin
            push <= 1'b0;
            case (st)
                H_PWR:
                begin
                    pw_cnt <= pw_cnt + PWW'(1);
                    if (pw_cnt == PWW'(PWRUP_CLKS - 1))
                        st <= H_SEQ;
                end
                H_SEQ:
                    if (eng_done)
                    begin
                        if (in_rb && rb_bad)
                            verify_err_o <= 1'b1;
                        sq <= sq + 5'h01;
                        if (sq == asr_pkg::SEQ_CONT)
                        begin
                            st <= H_RUN;
                            init_done_o <= 1'b1;
                        end
                    end
                H_RUN:
                    // Full buffer holds off the read until one entry is popped
                    if (rdy_low && !buf_full)
                    begin
                        nb <= 2'h0;
                        st <= CONT_MODE ? H_RDAT : H_RCMD;
                    end
                H_RCMD:
                    if (eng_done)
                        st <= H_RDAT;
                H_RDAT:
                    if (eng_done)
                    begin
                        acc <= {acc[15:0], eng_rx};
                        nb <= nb + 2'h1;
                        if (nb == NLAST)
                        begin
                            push <= 1'b1;
                            push_data <= CHK ? acc : {acc[15:0], eng_rx};
                            if (CHK && sum3 != eng_rx)
                                chk_err_o <= 1'b1;
                            st <= H_WHI;
                        end
                    end
                H_WHI:
                    if (!rdy_low)
                        st <= H_RUN;
                default: st <= H_PWR;
            endcase
        end
    end

    // ==========================================================
    // Pins
    always_ff @(posedge core_clk_i)
    begin
        if (rst_i)
        begin
            lnk.cs_n <= 1'b1;
            lnk.start <= 1'b0;
        end
        else
        begin
            lnk.cs_n <= (st == H_PWR);
            lnk.start <= init_done_o & ~START_BY_CMD &
                (USE_AMP_TRIG ? trig_sy[1] : 1'b1);
        end
    end

    // ==========================================================
    // Two-entry result buffer
    logic [23:0] mem [0:1];
    logic wp;
    logic rp;
    wire pop = res_valid_o & res_ready_i;

    always_ff @(posedge core_clk_i)
    begin
        if (rst_i)
        begin
            wp <= 1'b0;
            rp <= 1'b0;
            fcnt <= 2'h0;
            mem[0] <= 24'h000000;
            mem[1] <= 24'h000000;
        end
        else
        begin
            if (push)
            begin
                mem[wp] <= push_data;
                wp <= ~wp;
            end
            if (pop)
                rp <= ~rp;
            fcnt <= fcnt + {1'b0, push} - {1'b0, pop};
        end
    end
    assign res_valid_o = (fcnt != 2'h0);
    assign res_data_o = mem[rp];
endmodule
`default_nettype wire

// [asr_link_checker.sv]
// Link checker for the controller and converter ends.
// Assumes tb places it beside the link; result ready is checked on the converter clock.
`timescale 1ns/1ns
`default_nettype none
module asr_link_checker #(
    parameter int PWRUP_CLKS = asr_pkg::PWRUP_CLKS
) (
    input wire logic core_clk_i,
    input wire logic dev_clk_i,
    input wire logic rst_i,
    input wire logic sclk,
    input wire logic cs_n,
    input wire logic din,
    input wire logic dout_oe,
    input wire logic result_ready_n
);
    int quiet;
    default clocking @(posedge core_clk_i); endclocking
    default disable iff (rst_i);
    // Edges since reset, saturating at the power-up wait
    always_ff @(posedge core_clk_i)
    begin
        if (rst_i)
            quiet <= 0;
        else if (quiet < PWRUP_CLKS)
            quiet <= quiet + 1;
    end
    // ========================================
    // Framing and timing
    AST_PWRUP_QUIET: assert property (quiet < PWRUP_CLKS |-> cs_n)
        else $error("link used before power-up wait");
    AST_SCLK_SEL: assert property ($rose(sclk) |-> !cs_n)
        else $error("clock edge while deselected");
    AST_SCLK_HIGH: assert property ($rose(sclk) |-> sclk[*4] ##1 !sclk)
        else $error("clock high phase wrong");
    AST_SCLK_LOW: assert property ($fell(sclk) |-> !sclk[*4])
        else $error("clock low phase too short");
    AST_DIN_HOLD: assert property (sclk && $past(sclk) |-> $stable(din))
        else $error("data moved while clock high");
    // Deselect lag covers the converter clock crossing
    AST_OE_DESEL: assert property (cs_n[*8] |-> !dout_oe)
        else $error("data out driven while deselected");
    AST_READY_HOLD: assert property (@(posedge dev_clk_i)
        $fell(result_ready_n) |-> !result_ready_n[*8])
        else $error("ready pulse too short");
    AST_READY_CLEAR: assert property (@(posedge dev_clk_i)
        $fell(result_ready_n) |-> ##[1:1000] result_ready_n)
        else $error("result not fetched in time");
    cover property ($fell(cs_n));
    cover property ($fell(result_ready_n));
    cover property ($rose(dout_oe));
endmodule
`default_nettype wire

// [asr_link_if.sv]
// Serial link between the controller and the converter.
// Assumes the data-out line has a pull-down when released.
`timescale 1ns/1ns
`default_nettype none
interface asr_link_if;
    logic sclk;
    logic cs_n;
    logic din;
    logic dout;
    logic dout_oe;
    logic start;
    logic result_ready_n;
    logic miso;
    // Released line reads low through the pull-down
    assign miso = dout_oe ? dout : 1'b0;
    modport dev(input sclk, input cs_n, input din, input start,
        output dout, output dout_oe, output result_ready_n);
    modport host(output sclk, output cs_n, output din, output start,
        input miso, input result_ready_n);
endinterface
`default_nettype wire

// [asr_pkg.sv]
// Constants shared by both ends of the converter serial start-up link.
// Assumes one converter on the link with a fixed nine-byte register block.
`default_nettype none
package asr_pkg;
    // ==========================================================
    // Opcodes
    localparam logic [7:0] OP_NOP = 8'h00;
    localparam logic [7:0] OP_START = 8'h08;
    localparam logic [7:0] OP_CONT = 8'h10;
    localparam logic [7:0] OP_STOP_CONT = 8'h11;
    localparam logic [7:0] OP_RDATA = 8'h12;
    localparam logic [3:0] OP_WREG_HI = 4'h4;
    localparam logic [3:0] OP_RREG_HI = 4'h2;
    localparam logic [7:0] BLOCK_M1 = 8'h08;
    // ==========================================================
    // Register block
    localparam int NREG = 9;
    localparam logic [3:0] REG_SETUP0 = 4'h0;
    localparam logic [3:0] REG_SETUP1 = 4'h1;
    localparam logic [3:0] REG_SETUP2 = 4'h2;
    localparam logic [3:0] REG_GAIN2 = 4'h8;
    localparam int B_TMO_EN = 0;
    localparam int B_CHK_EN = 6;
    localparam int B_READY = 7;
    localparam logic [7:0] SETUP0_VAL = 8'h05;
    localparam logic [7:0] SETUP1_VAL = 8'h50;
    localparam logic [7:0] SETUP2_VAL = 8'h03;
    localparam logic [7:0] GAIN2_VAL = 8'h40;
    localparam logic [7:0] RST_SETUP0 = 8'h05;
    localparam logic [7:0] RST_SETUP1 = 8'h08;
    localparam logic [7:0] RST_SETUP2 = 8'h00;
    localparam logic [7:0] RST_GAIN2 = 8'h40;
    // ==========================================================
    // Host sequence positions and timing counts
    localparam logic [4:0] SEQ_WDATA = 5'h03;
    localparam logic [4:0] SEQ_RCMD = 5'h0c;
    localparam logic [4:0] SEQ_RDATA = 5'h0e;
    localparam logic [4:0] SEQ_RLAST = 5'h16;
    localparam logic [4:0] SEQ_START = 5'h17;
    localparam logic [4:0] SEQ_CONT = 5'h18;
    localparam int SER_TMO_CLKS = 65536;
    localparam int PWRUP_CLKS = 65536;

    function automatic logic [7:0] init_val(input logic [3:0] a);
        case (a)
            REG_SETUP0: init_val = SETUP0_VAL;
            REG_SETUP1: init_val = SETUP1_VAL;
            REG_SETUP2: init_val = SETUP2_VAL;
            REG_GAIN2: init_val = GAIN2_VAL;
            default: init_val = 8'h00;
        endcase
    endfunction

    function automatic logic [7:0] reg_reset(input logic [3:0] a);
        case (a)
            REG_SETUP0: reg_reset = RST_SETUP0;
            REG_SETUP1: reg_reset = RST_SETUP1;
            REG_SETUP2: reg_reset = RST_SETUP2;
            REG_GAIN2: reg_reset = RST_GAIN2;
            default: reg_reset = 8'h00;
        endcase
    endfunction
endpackage
`default_nettype wire

// [tb.sv]
// Testbench joining both ends of the link.
// Assumes short power-up and timeout counts of 64.
`timescale 1ns/1ns
`default_nettype none
module tb;
    logic core_clk_i, dev_clk, rst_i;
    logic [23:0] result_i, res_data_o;
    logic result_valid_i, res_ready_i, res_valid_o;
    logic conv_run_o, init_done_o, verify_err_o, chk_err_o;
    logic [2:0] rate_sel_o;
    logic [7:0] sh;
    logic [7:0] seen [0:63];
    logic [7:0] exp_b [0:13] = '{8'h11, 8'h40, 8'h08, 8'h05, 8'h50, 8'h03,
        8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h40, 8'h20, 8'h08};
    int err_total, cmp_count, nbit, nbyte, n;
    asr_link_if lnk();
    asr_host #(.PWRUP_CLKS(64)) asr_host_inst (.core_clk_i(core_clk_i),
        .rst_i(rst_i), .lnk(lnk), .amp_trigger_i(1'b0),
        .res_data_o(res_data_o), .res_valid_o(res_valid_o),
        .res_ready_i(res_ready_i), .init_done_o(init_done_o),
        .verify_err_o(verify_err_o), .chk_err_o(chk_err_o));
    asr_dev #(.TMO_CLKS(64)) asr_dev_inst (.core_clk_i(dev_clk),
        .rst_i(rst_i), .lnk(lnk), .result_i(result_i),
        .result_valid_i(result_valid_i), .conv_run_o(conv_run_o),
        .rate_sel_o(rate_sel_o));
    asr_link_checker #(.PWRUP_CLKS(64)) asr_link_checker_inst (
        .core_clk_i(core_clk_i), .dev_clk_i(dev_clk),
        .rst_i(rst_i), .sclk(lnk.sclk), .cs_n(lnk.cs_n), .din(lnk.din),
        .dout_oe(lnk.dout_oe), .result_ready_n(lnk.result_ready_n));
    initial
    begin
        core_clk_i = 1'b0;
        forever #25 core_clk_i = ~core_clk_i;
    end
    // Offset start keeps the converter clock out of phase
    initial
    begin
        dev_clk = 1'b0;
        #7;
        forever #32 dev_clk = ~dev_clk;
    end
    // ========================================
    // Byte capture on the wire
    always @(posedge lnk.sclk)
    begin
        if (!lnk.cs_n)
        begin
            sh = {sh[6:0], lnk.din};
            nbit = (nbit + 1) % 8;
            if (nbit == 0)
                seen[nbyte % 64] = sh;
            if (nbit == 0)
                nbyte++;
        end
    end
    // ========================================
    // Access tasks
    task check(input logic [24:0] got, input logic [24:0] exp);
        cmp_count++;
        if (got !== exp)
        begin
            err_total++;
            $display("[FAIL] %0t got %h exp %h", $time, got, exp);
        end
    endtask
    task put_result(input logic [23:0] w);
        @(posedge dev_clk);
        result_i <= w;
        result_valid_i <= 1'b1;
        @(posedge dev_clk);
        result_valid_i <= 1'b0;
        repeat (500) @(posedge core_clk_i);
    endtask
    task get_result(input logic [23:0] exp);
        n = 0;
        do
        begin
            @(posedge core_clk_i);
            n++;
        end while (res_valid_o !== 1'b1 && n < 2000);
        check({res_valid_o, res_data_o}, {1'b1, exp});
        res_ready_i <= 1'b1;
        @(posedge core_clk_i);
        res_ready_i <= 1'b0;
    endtask
    task conclude;
        $display("compares %0d mismatches %0d", cmp_count, err_total);
        if (err_total == 0 && cmp_count > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask
    // ========================================
    // Tests
    initial
    begin
        rst_i = 1'b1;
        result_i = 24'h0;
        result_valid_i = 1'b0;
        res_ready_i = 1'b0;
        nbit = 0;
        nbyte = 0;
        repeat (10) @(posedge core_clk_i);
        rst_i <= 1'b0;
        for (int i = 0; i < 6000 && init_done_o !== 1'b1; i++)
            @(posedge core_clk_i);
        repeat (400) @(posedge core_clk_i);
        check({22'h0, verify_err_o, chk_err_o, init_done_o}, 25'h1);
        for (int i = 0; i < 14; i++)
            check({17'h0, seen[i]}, {17'h0, exp_b[i]});
        check({17'h0, seen[23]}, 25'h0);
        check({17'h0, seen[24]}, 25'h10);
        check({21'h0, conv_run_o, rate_sel_o}, 25'hb);
        $display("test start-up done");
        // Two fill the buffer; the third waits until the first is popped
        put_result(24'ha5c3e1);
        put_result(24'h0f1e2d);
        put_result(24'h800001);
        get_result(24'ha5c3e1);
        get_result(24'h0f1e2d);
        get_result(24'h800001);
        check({23'h0, verify_err_o, chk_err_o}, 25'h0);
        $display("test result stream done");
        conclude;
    end
    initial
    begin
        repeat (20000) @(posedge core_clk_i);
        err_total++;
        $display("[FAIL] %0t watchdog expired", $time);
        conclude;
    end
endmodule
`default_nettype wire
